/* File: shared/psw_params.svh */
/*
 * Offsets, field positions, reset values and fixed capability figures for the
 * per-port error-reporting and virtual-channel register bank.
 * Assumes it is included by bare name and that nothing else defines these names.
 */
// Contract
// - Severity bit: 0 non-fatal, 1 fatal.
// - Correctable status flags set on detection, W1C.
// - Masked correctable event: no log, no message.
// - First error pointer, read-only, resets zero.
// - ECRC capable bits one; enables at 6,8.
// - Header log: four words, first word lowest.
// - VC header: id 0002h, version 1, next 20Ch.
// - Extended VC count, preloadable, selects defaults.
// - Arbitration reference clock reads 00b.
// - Port table entry size reads 10b.
// - VC arbitration cap/offset: 00h or 03h.
// - VC table load bit reads zero.
// - VC arbitration select: only 0,1 kept.
// - VC table status: set on write, load clears.
// - Port arbitration cap: 09h; VC1 00h/19h.
// - Maximum time slots 7Fh; VC1 00h/7Fh.
// - Port table offset 04h; table1 00h/08h.
// - TC map, default FFh, preloadable.
// - Port table load bit reads zero.
// - Port arbitration select: only 000b,011b kept.
// - VC0 id 000b; enable defaults one.
// - VC0 status: table bit 16, pending 17.
`ifndef PSW_PARAMS_SVH
`define PSW_PARAMS_SVH

// Register byte offsets.
`define PSW_OFF_SEV 12'h10C
`define PSW_OFF_COR_STS 12'h110
`define PSW_OFF_COR_MSK 12'h114
`define PSW_OFF_AER_CTL 12'h118
`define PSW_OFF_HDR0 12'h11C
`define PSW_OFF_HDR3 12'h128
`define PSW_OFF_VC_HDR 12'h140
`define PSW_OFF_VC_CAP1 12'h144
`define PSW_OFF_VC_CAP2 12'h148
`define PSW_OFF_VC_CTL 12'h14C
`define PSW_OFF_VC0_CAP 12'h150
`define PSW_OFF_VC0_CTL 12'h154
`define PSW_OFF_VC0_STS 12'h158
`define PSW_OFF_VC1_CAP 12'h15C

// Writable bits and reset values.
`define PSW_SEV_WMASK 32'h003FF011
`define PSW_SEV_RST 32'h00062011
`define PSW_COR_MASK 32'h000031C1
`define PSW_COR_MSK_RST 32'h00002000
`define PSW_TC_MAP_RST 8'hFF

// Field positions.
`define PSW_BIT_ECRC_GEN_CAP 5
`define PSW_BIT_ECRC_GEN_EN 6
`define PSW_BIT_ECRC_CHK_CAP 7
`define PSW_BIT_ECRC_CHK_EN 8
`define PSW_BIT_VC_LOAD 0
`define PSW_BIT_TBL_STS 16
`define PSW_BIT_PA_LOAD 16
`define PSW_BIT_NEG_PEND 17
`define PSW_BIT_VC_EN 31

// Fixed capability figures.
`define PSW_VC_CAP_ID 16'h0002
`define PSW_VC_CAP_VER 4'h1
`define PSW_VC_NEXT 12'h20C
`define PSW_REF_CLK 2'b00
`define PSW_ENTRY_SIZE 2'b10
`define PSW_VC_ARB_ONE 8'h03
`define PSW_PA_CAP0 8'h09
`define PSW_PA_CAP1 8'h19
`define PSW_MTS 7'h7F
`define PSW_PA_OFF0 8'h04
`define PSW_PA_OFF1 8'h08
`define PSW_PA_SEL_ALT 3'b011

`endif

/* File: shared/psw_pkg.sv */
/*
 * Types shared by the register bank and its users.
 * Assumes the configuration request path delivers one request per cycle.
 */
package psw_pkg;

    // One configuration request, byte addressed, dword aligned.
    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
    } psw_cfg_req_t;

    // Error events from the link and transaction layers.
    typedef struct packed {
        logic [5:0] cor;
        logic cor_hdr;
        logic unc;
        logic [4:0] unc_bit;
        logic unc_clr;
        logic [127:0] hdr;
    } psw_err_evt_t;

    // Sideband management or preload values.
    typedef struct packed {
        logic valid;
        logic [2:0] ext_vc;
        logic [7:0] tc_map;
    } psw_mgmt_t;

    // Controls that steer the port's datapath.
    typedef struct packed {
        logic [31:0] sev;
        logic ecrc_gen;
        logic ecrc_chk;
        logic [2:0] vc_arb_sel;
        logic [2:0] pa_sel;
        logic [7:0] tc_map;
        logic vc0_en;
    } psw_ctl_t;

endpackage

/* File: hw/psw_regs.sv */
/*
 * Error-reporting and virtual-channel configuration registers of one switch port.
 * Assumes all event inputs come from logic on mclk_i and that the uncorrectable
 * event input has already been filtered by the uncorrectable mask elsewhere.
 */
`timescale 1ns/1ps
`include "psw_params.svh"

module psw_regs (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_i,
    // Configuration requests.
    input wire psw_pkg::psw_cfg_req_t cfg_i,
    output logic cfg_ack_o,
    output logic [31:0] cfg_rdata_o,
    // Error events and error message request.
    input wire psw_pkg::psw_err_evt_t evt_i,
    output logic cor_msg_o,
    // Sideband management preload.
    input wire psw_pkg::psw_mgmt_t mgmt_i,
    // Arbitration table handshakes.
    input wire logic vc_tbl_wr_i,
    input wire logic vc_load_done_i,
    input wire logic pa_tbl_wr_i,
    input wire logic pa_load_done_i,
    input wire logic vc0_neg_pend_i,
    output logic vc_load_o,
    output logic pa_load_o,
    // Datapath controls.
    output psw_pkg::psw_ctl_t ctl_o
);
    import psw_pkg::*;

    // Severity bits, one per uncorrectable error.
    logic [31:0] sev;
    // Correctable status and mask.
    logic [31:0] cor_sts;
    logic [31:0] cor_msk;
    // ECRC enables.
    logic ecrc_gen;
    logic ecrc_chk;
    // First error pointer and its hold flag.
    logic [4:0] fep;
    logic fep_held;
    // Header log words, index 0 is the first header word.
    logic [31:0] hdr_log [4];
    // Extended VC count and TC map.
    logic [2:0] ext_vc;
    logic [7:0] tc_map;
    // Arbitration selects, enable and table status.
    logic [2:0] vc_arb_sel;
    logic [2:0] pa_sel;
    logic vc0_en;
    logic vc_tbl_sts;
    logic pa_tbl_sts;
    logic neg_pend;
    // Read data and acknowledge.
    logic [31:0] next_rdata;
    logic ack;
    logic [31:0] rdata;
    logic cor_msg;
    logic vc_load;
    logic pa_load;

    // Decoded write strobes and byte-lane mask.
    logic wr;
    logic [31:0] wmask;
    logic [31:0] wd;
    logic [31:0] cor_evt;
    logic vc_one;

    assign wr = cfg_i.valid & cfg_i.write;
    assign wd = cfg_i.wdata;
    assign wmask = {{8{cfg_i.be[3]}}, {8{cfg_i.be[2]}}, {8{cfg_i.be[1]}}, {8{cfg_i.be[0]}}};
    // Only a count of exactly one enables the second channel's defaults.
    assign vc_one = (ext_vc == 3'h1);

    // Spread the six correctable event lines onto their status positions.
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_cor
            if (gi == 0) begin : g_b0
                assign cor_evt[gi] = evt_i.cor[0];
            end else if (gi == 6 || gi == 7 || gi == 8) begin : g_b678
                assign cor_evt[gi] = evt_i.cor[gi - 5];
            end else if (gi == 12 || gi == 13) begin : g_b1213
                assign cor_evt[gi] = evt_i.cor[gi - 8];
            end else begin : g_rsv
                assign cor_evt[gi] = 1'b0;
            end
        end
    endgenerate

    // Severity register; reserved positions never take a write.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sev <= `PSW_SEV_RST;
        end else if (wr && cfg_i.addr == `PSW_OFF_SEV) begin
            sev <= (sev & ~(wmask & `PSW_SEV_WMASK)) | (wd & wmask & `PSW_SEV_WMASK);
        end
    end

    // Correctable status: a new event beats a clear in the same cycle.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cor_sts <= 32'h00000000;
        end else begin
            if (wr && cfg_i.addr == `PSW_OFF_COR_STS) begin
                cor_sts <= ((cor_sts & ~(wd & wmask)) | cor_evt) & `PSW_COR_MASK;
            end else begin
                cor_sts <= (cor_sts | cor_evt) & `PSW_COR_MASK;
            end
        end
    end

    // Correctable mask register.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cor_msk <= `PSW_COR_MSK_RST;
        end else if (wr && cfg_i.addr == `PSW_OFF_COR_MSK) begin
            cor_msk <= (cor_msk & ~(wmask & `PSW_COR_MASK)) | (wd & wmask & `PSW_COR_MASK);
        end
    end

    // Error message request: any unmasked correctable event, one pulse.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cor_msg <= 1'b0;
        end else begin
            cor_msg <= |(cor_evt & ~cor_msk);
        end
    end

    // ECRC generate enable lives in byte lane zero and check enable in byte lane one of the control word.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ecrc_gen <= 1'b0;
            ecrc_chk <= 1'b0;
        end else if (wr && cfg_i.addr == `PSW_OFF_AER_CTL) begin
            if (cfg_i.be[0]) begin
                ecrc_gen <= wd[`PSW_BIT_ECRC_GEN_EN];
            end
            if (cfg_i.be[1]) begin
                ecrc_chk <= wd[`PSW_BIT_ECRC_CHK_EN];
            end
        end
    end

    // First error pointer holds until the uncorrectable status empties.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            fep <= 5'h00;
            fep_held <= 1'b0;
        end else if (evt_i.unc && !fep_held) begin
            fep <= evt_i.unc_bit;
            fep_held <= 1'b1;
        end else if (evt_i.unc_clr) begin
            fep_held <= 1'b0;
        end
    end

    // Header log, captured on logged errors; a masked event leaves it alone.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 4; i++) begin
                hdr_log[i] <= 32'h00000000;
            end
        end else if (evt_i.unc || (evt_i.cor_hdr && |(cor_evt & ~cor_msk))) begin
            for (int i = 0; i < 4; i++) begin
                hdr_log[i] <= evt_i.hdr[32 * i +: 32];
            end
        end
    end

    // Extended VC count and TC map take sideband preload values.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ext_vc <= 3'h0;
        end else if (mgmt_i.valid) begin
            ext_vc <= mgmt_i.ext_vc;
        end
    end

    // TC map: software writes and sideband preload; preload wins on a tie.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tc_map <= `PSW_TC_MAP_RST;
        end else if (mgmt_i.valid) begin
            tc_map <= mgmt_i.tc_map;
        end else if (wr && cfg_i.addr == `PSW_OFF_VC0_CTL && cfg_i.be[0]) begin
            tc_map <= wd[7:0];
        end
    end

    // VC arbitration select; an illegal code falls back to the default.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            vc_arb_sel <= 3'h0;
        end else if (wr && cfg_i.addr == `PSW_OFF_VC_CTL && cfg_i.be[0]) begin
            vc_arb_sel <= (wd[3:1] <= 3'h1) ? wd[3:1] : 3'h0;
        end
    end

    // Port arbitration select and channel enable of VC0.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pa_sel <= 3'h0;
            vc0_en <= 1'b1;
        end else if (wr && cfg_i.addr == `PSW_OFF_VC0_CTL) begin
            if (cfg_i.be[2]) begin
                pa_sel <= (wd[19:17] == `PSW_PA_SEL_ALT) ? `PSW_PA_SEL_ALT : 3'h0;
            end
            if (cfg_i.be[3]) begin
                vc0_en <= wd[`PSW_BIT_VC_EN];
            end
        end
    end

    // Load strobes: one pulse, the stored bit itself never exists.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            vc_load <= 1'b0;
            pa_load <= 1'b0;
        end else begin
            vc_load <= wr && cfg_i.addr == `PSW_OFF_VC_CTL && cfg_i.be[0]
                && wd[`PSW_BIT_VC_LOAD];
            pa_load <= wr && cfg_i.addr == `PSW_OFF_VC0_CTL && cfg_i.be[2]
                && wd[`PSW_BIT_PA_LOAD];
        end
    end

    // Table status bits; a table write beats a load completion.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            vc_tbl_sts <= 1'b0;
            pa_tbl_sts <= 1'b0;
            neg_pend <= 1'b0;
        end else begin
            vc_tbl_sts <= vc_tbl_wr_i | (vc_tbl_sts & ~vc_load_done_i);
            pa_tbl_sts <= pa_tbl_wr_i | (pa_tbl_sts & ~pa_load_done_i);
            neg_pend <= vc0_neg_pend_i;
        end
    end

    // Read multiplexer; unmapped offsets and reserved bits read zero.
    always_comb begin
        next_rdata = 32'h00000000;
        case (cfg_i.addr)
            `PSW_OFF_SEV: next_rdata = sev;
            `PSW_OFF_COR_STS: next_rdata = cor_sts;
            `PSW_OFF_COR_MSK: next_rdata = cor_msk;
            `PSW_OFF_AER_CTL: begin
                next_rdata[4:0] = fep;
                next_rdata[`PSW_BIT_ECRC_GEN_CAP] = 1'b1;
                next_rdata[`PSW_BIT_ECRC_GEN_EN] = ecrc_gen;
                next_rdata[`PSW_BIT_ECRC_CHK_CAP] = 1'b1;
                next_rdata[`PSW_BIT_ECRC_CHK_EN] = ecrc_chk;
            end
            12'h11C: next_rdata = hdr_log[0];
            12'h120: next_rdata = hdr_log[1];
            12'h124: next_rdata = hdr_log[2];
            `PSW_OFF_HDR3: next_rdata = hdr_log[3];
            `PSW_OFF_VC_HDR: next_rdata = {`PSW_VC_NEXT, `PSW_VC_CAP_VER, `PSW_VC_CAP_ID};
            `PSW_OFF_VC_CAP1: begin
                next_rdata[2:0] = ext_vc;
                next_rdata[9:8] = `PSW_REF_CLK;
                next_rdata[11:10] = `PSW_ENTRY_SIZE;
            end
            `PSW_OFF_VC_CAP2: begin
                next_rdata[7:0] = vc_one ? `PSW_VC_ARB_ONE : 8'h00;
                next_rdata[31:24] = vc_one ? `PSW_VC_ARB_ONE : 8'h00;
            end
            `PSW_OFF_VC_CTL: begin
                next_rdata[3:1] = vc_arb_sel;
                next_rdata[`PSW_BIT_TBL_STS] = vc_tbl_sts;
            end
            `PSW_OFF_VC0_CAP: begin
                next_rdata[7:0] = `PSW_PA_CAP0;
                next_rdata[22:16] = `PSW_MTS;
                next_rdata[31:24] = `PSW_PA_OFF0;
            end
            `PSW_OFF_VC0_CTL: begin
                next_rdata[7:0] = tc_map;
                next_rdata[19:17] = pa_sel;
                next_rdata[`PSW_BIT_VC_EN] = vc0_en;
            end
            `PSW_OFF_VC0_STS: begin
                next_rdata[`PSW_BIT_TBL_STS] = pa_tbl_sts;
                next_rdata[`PSW_BIT_NEG_PEND] = neg_pend;
            end
            `PSW_OFF_VC1_CAP: begin
                next_rdata[7:0] = vc_one ? `PSW_PA_CAP1 : 8'h00;
                next_rdata[22:16] = vc_one ? `PSW_MTS : 7'h00;
                next_rdata[31:24] = vc_one ? `PSW_PA_OFF1 : 8'h00;
            end
            default: next_rdata = 32'h00000000;
        endcase
    end

    // Every request is answered one cycle later; writes return zero data.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            rdata <= 32'h00000000;
        end else begin
            ack <= cfg_i.valid;
            rdata <= (cfg_i.valid && !cfg_i.write) ? next_rdata : 32'h00000000;
        end
    end

    assign cfg_ack_o = ack;
    assign cfg_rdata_o = rdata;
    assign cor_msg_o = cor_msg;
    assign vc_load_o = vc_load;
    assign pa_load_o = pa_load;
    assign ctl_o = '{sev: sev, ecrc_gen: ecrc_gen, ecrc_chk: ecrc_chk,
        vc_arb_sel: vc_arb_sel, pa_sel: pa_sel, tc_map: tc_map, vc0_en: vc0_en};

    // Checks on the register behaviour.
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sev_reset_a: assert property ($rose(!rst_i) |-> sev == `PSW_SEV_RST)
        else $error("severity default wrong");

    cor_set_a: assert property (evt_i.cor[0] |=> cor_sts[0])
        else $error("receiver error flag not set");

    // Any event whose lines are all masked must stay silent.
    cor_mask_a: assert property (
        (evt_i.cor != 6'h00 && (cor_evt & ~cor_msk) == 32'h00000000) |=> !cor_msg)
        else $error("masked event raised a message");

    // A header offered with only masked events must leave the first log word alone.
    hdr_keep_a: assert property (
        (evt_i.cor_hdr && !evt_i.unc && (cor_evt & ~cor_msk) == 32'h00000000)
        |=> hdr_log[0] == $past(hdr_log[0]))
        else $error("masked event overwrote header log");

    fep_hold_a: assert property ((evt_i.unc && !fep_held) |=> fep == $past(evt_i.unc_bit))
        else $error("first error pointer not captured");

    ecrc_rd_a: assert property (
        (cfg_i.valid && !cfg_i.write && cfg_i.addr == `PSW_OFF_AER_CTL)
        |=> cfg_rdata_o[5] && cfg_rdata_o[7])
        else $error("ECRC capable bits not one");

    vc_load_rd_a: assert property (
        (cfg_i.valid && cfg_i.addr == `PSW_OFF_VC_CTL) |=> !cfg_rdata_o[0])
        else $error("VC load bit read back one");

    pa_load_pulse_a: assert property (
        (wr && cfg_i.addr == `PSW_OFF_VC0_CTL && cfg_i.be[2] && wd[`PSW_BIT_PA_LOAD])
        |=> pa_load_o)
        else $error("port table load not pulsed");

    vc_sel_legal_a: assert property (
        (wr && cfg_i.addr == `PSW_OFF_VC_CTL && cfg_i.be[0] && wd[3:1] > 3'h1)
        |=> vc_arb_sel == 3'h0)
        else $error("illegal VC arbitration select kept");

    vc_tbl_sts_a: assert property (vc_tbl_wr_i |=> vc_tbl_sts [*1] ##1 1'b1)
        else $error("VC table status not set on write");

    pa_sel_legal_a: assert property (
        (wr && cfg_i.addr == `PSW_OFF_VC0_CTL && cfg_i.be[2]
        && wd[19:17] != `PSW_PA_SEL_ALT) |=> pa_sel == 3'h0)
        else $error("illegal port arbitration select kept");

    pa_tbl_sts_a: assert property (pa_tbl_wr_i |=> pa_tbl_sts)
        else $error("port table status not set on write");

    vc0_en_wr_a: assert property (
        (wr && cfg_i.addr == `PSW_OFF_VC0_CTL && cfg_i.be[3])
        |=> vc0_en == $past(wd[`PSW_BIT_VC_EN]))
        else $error("channel enable not written");

    cfg_ack_a: assert property (cfg_i.valid |=> cfg_ack_o ##1 (cfg_ack_o == $past(cfg_i.valid)))
        else $error("request not acknowledged in one cycle");
endmodule

/* File: test/psw_rc_model.sv */
/*
 * Root complex model: sends queued configuration requests to the port.
 * Assumes the bench pushes requests only after reset has been released.
 */
`timescale 1ns/1ps

module psw_rc_model (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_i,
    // Request toward the port.
    output psw_pkg::psw_cfg_req_t cfg_o
);
    import psw_pkg::*;

    // Requests waiting to go out, oldest first.
    psw_cfg_req_t req_q[$];

    // Queues one dword request; queued requests leave back to back.
    task automatic push(input logic wr, input logic [11:0] addr, input logic [31:0] data,
            input logic [3:0] be);
        req_q.push_back('{1'b1, wr, addr, data, be});
    endtask

    // One request per edge; when idle the qualifiers keep toggling so the port
    // cannot lean on stale address or data.
    initial cfg_o = '0;
    always @(posedge mclk_i) begin
        #1;
        if (!rst_i && req_q.size() > 0) begin
            cfg_o = req_q.pop_front();
        end else begin
            cfg_o = {1'b0, ~cfg_o.write, ~cfg_o.addr, ~cfg_o.wdata, ~cfg_o.be};
        end
    end
endmodule

/* File: test/psw_regs_tb.sv */
/*
 * Self-checking bench for the port's error and virtual-channel registers.
 * Assumes the root complex model in psw_rc_model.sv and a 40 MHz clock.
 */
`timescale 1ns/1ps

module psw_regs_tb;
    import psw_pkg::*;

    // One expected answer: address, read data and load pulses.
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [1:0] ld;
    } psw_note_t;

    logic mclk_i;
    logic rst_i;
    psw_cfg_req_t cfg;
    logic cfg_ack_o;
    logic [31:0] cfg_rdata_o;
    psw_err_evt_t evt;
    logic cor_msg_o;
    psw_mgmt_t mgmt;
    logic [4:0] side; // Table write and done pulses, then the pending level.
    logic vc_load_o;
    logic pa_load_o;
    psw_ctl_t ctl_o;
    psw_note_t note_q[$];
    psw_note_t n;
    logic [127:0] hdr;
    logic [31:0] old;
    logic [7:0] tc;
    int bad_count;
    int cmp_count;
    int cb[6] = '{0, 6, 7, 8, 12, 13};

    // Free-running 25 ns clock.
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    psw_rc_model rc (.mclk_i(mclk_i), .rst_i(rst_i), .cfg_o(cfg));

    psw_regs dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .cfg_i(cfg), .cfg_ack_o(cfg_ack_o),
        .cfg_rdata_o(cfg_rdata_o), .evt_i(evt), .cor_msg_o(cor_msg_o), .mgmt_i(mgmt),
        .vc_tbl_wr_i(side[4]), .vc_load_done_i(side[3]), .pa_tbl_wr_i(side[2]),
        .pa_load_done_i(side[1]), .vc0_neg_pend_i(side[0]), .vc_load_o(vc_load_o),
        .pa_load_o(pa_load_o), .ctl_o(ctl_o)
    );

    // Prints the counts and the verdict, then stops.
    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Compares one directly sampled value.
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Compares one answer against the oldest note.
    task automatic cmp_ack(input psw_note_t e, input logic [31:0] d, input logic [1:0] ld);
        cmp_count++;
        if (d !== e.data || ld !== e.ld) begin
            bad_count++;
            $display("wrong value reg %h expected %h/%b seen %h/%b", e.addr, e.data, e.ld, d, ld);
        end
    endtask

    // Watches acknowledges; an answer nobody asked for is a mismatch too.
    always @(posedge mclk_i) begin
        if (cfg_ack_o === 1'b1) begin
            if (note_q.size() == 0) begin
                bad_count++;
                $display("wrong value cfg_ack_o expected 0 seen 1");
            end else begin
                n = note_q.pop_front();
                cmp_ack(n, cfg_rdata_o, {vc_load_o, pa_load_o});
            end
        end
    end

    // Read with random write data on the unused lanes of the request.
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rc.push(1'b0, a, $urandom, 4'hF);
        note_q.push_back('{a, e, 2'b00});
    endtask

    // Write; a write answers with zero data and the expected load pulses.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be,
            input logic [1:0] ld);
        rc.push(1'b1, a, d, be);
        note_q.push_back('{a, 32'h0, ld});
    endtask

    // Waits, bounded, until every queued request has been answered.
    task automatic sync();
        int i;
        i = 0;
        while (note_q.size() > 0 && i < 64) begin
            @(posedge mclk_i);
            #1;
            i++;
        end
        if (note_q.size() > 0) begin
            bad_count++;
            $display("wrong value pending answers expected 0 seen %0d", note_q.size());
            final_report();
        end
    endtask

    // One-cycle error event with a fresh header, then the message check.
    task automatic ev(input logic [5:0] c, input logic u, input logic [4:0] ub, input logic clr,
            input logic msg);
        hdr = {$urandom, $urandom, $urandom, $urandom};
        @(posedge mclk_i);
        #1;
        evt = '{c, 1'b1, u, ub, clr, hdr};
        @(posedge mclk_i);
        #1;
        evt = '{6'h0, 1'b0, 1'b0, ~ub, 1'b0, ~hdr};
        chk("cor_msg_o", msg, cor_msg_o);
    endtask

    // One-cycle pulse on the table write and done inputs.
    task automatic sd(input logic [3:0] p);
        @(posedge mclk_i);
        #1;
        side[4:1] = p;
        @(posedge mclk_i);
        #1;
        side[4:1] = 4'h0;
    endtask

    // Sideband preload pulse with a random channel map.
    task automatic mg(input logic [2:0] x);
        tc = $urandom;
        @(posedge mclk_i);
        #1;
        mgmt = '{1'b1, x, tc};
        @(posedge mclk_i);
        #1;
        mgmt = '{1'b0, ~x, ~tc};
    endtask

    // Hang guard far above the few hundred cycles the sequence needs.
    initial begin
        repeat (20000) @(posedge mclk_i);
        bad_count++;
        $display("wrong value run length expected end seen limit");
        final_report();
    end

    // Main sequence.
    initial begin
        int v;
        logic [2:0] s;
        void'($urandom(32'hE09CE6ED));
        rst_i = 1'b1;
        evt = '0;
        mgmt = '0;
        side = 5'h0;
        bad_count = 0;
        cmp_count = 0;
        repeat (5) @(posedge mclk_i);
        #1;
        rst_i = 1'b0;
        rd(12'h10C, 32'h00062011);
        rd(12'h110, 32'h0);
        rd(12'h114, 32'h00002000);
        rd(12'h118, 32'h000000A0);
        rd(12'h140, 32'h20C10002);
        rd(12'h144, 32'h00000800);
        rd(12'h148, 32'h0);
        rd(12'h14C, 32'h0);
        rd(12'h150, 32'h047F0009);
        rd(12'h154, 32'h800000FF);
        rd(12'h158, 32'h0);
        rd(12'h15C, 32'h0);
        rd(12'h204, 32'h0);
        sync();
        chk("ctl_o", {32'h00062011, 8'h00, 8'hFF, 1'b1}, ctl_o);
        $display("test reset values done");
        mg(3'h1);
        rd(12'h144, 32'h00000801);
        rd(12'h148, 32'h03000003);
        rd(12'h15C, 32'h087F0019);
        rd(12'h154, {24'h800000, tc});
        sync();
        $display("test preload done");
        wr(12'h114, 32'hFFFFFFFF, 4'hF, 2'b00);
        rd(12'h114, 32'h000031C1);
        wr(12'h114, 32'h0, 4'hF, 2'b00);
        sync();
        for (v = 0; v < 6; v++) begin
            ev(6'(1 << v), 1'b0, 5'h0, 1'b0, 1'b1);
            rd(12'h110, 32'(1) << cb[v]);
            rd(12'h11C, hdr[31:0]);
            rd(12'h128, hdr[127:96]);
            wr(12'h110, ~(32'(1) << cb[v]), 4'hF, 2'b00);
            rd(12'h110, 32'(1) << cb[v]);
            wr(12'h110, 32'(1) << cb[v], 4'hF, 2'b00);
            rd(12'h110, 32'h0);
            sync();
        end
        old = hdr[31:0];
        wr(12'h114, 32'h000031C1, 4'hF, 2'b00);
        sync();
        ev(6'h3F, 1'b0, 5'h0, 1'b0, 1'b0);
        rd(12'h110, 32'h000031C1);
        rd(12'h11C, old);
        wr(12'h110, 32'hFFFFFFFF, 4'hF, 2'b00);
        rd(12'h110, 32'h0);
        sync();
        $display("test correctable errors done");
        ev(6'h0, 1'b1, 5'd14, 1'b0, 1'b0);
        rd(12'h118, 32'h000000AE);
        rd(12'h124, hdr[95:64]);
        sync();
        ev(6'h0, 1'b1, 5'd20, 1'b0, 1'b0);
        rd(12'h118, 32'h000000AE);
        sync();
        ev(6'h0, 1'b0, 5'h0, 1'b1, 1'b0);
        ev(6'h0, 1'b1, 5'd18, 1'b0, 1'b0);
        wr(12'h118, 32'hFFFFFFFF, 4'hF, 2'b00);
        rd(12'h118, 32'h000001F2);
        sync();
        chk("ecrc", 2'b11, {ctl_o.ecrc_gen, ctl_o.ecrc_chk});
        wr(12'h10C, 32'hFFFFFFFF, 4'hF, 2'b00);
        rd(12'h10C, 32'h003FF011);
        wr(12'h10C, 32'h0, 4'b0010, 2'b00);
        rd(12'h10C, 32'h003F0011);
        sync();
        chk("sev", 32'h003F0011, ctl_o.sev);
        $display("test advanced error control done");
        for (v = 0; v < 8; v++) begin
            s = (v <= 1) ? 3'(v) : 3'h0;
            wr(12'h14C, {16'hFFFF, 12'hFFF, 3'(v), 1'b1}, 4'hF, 2'b10);
            rd(12'h14C, {28'h0, s, 1'b0});
            sync();
            chk("vc_arb_sel", s, ctl_o.vc_arb_sel);
        end
        wr(12'h14C, 32'h1, 4'hE, 2'b00);
        sd(4'b1000);
        rd(12'h14C, 32'h00010000);
        sync();
        sd(4'b0100);
        rd(12'h14C, 32'h0);
        sync();
        $display("test port channel control done");
        for (v = 0; v < 8; v++) begin
            s = (v == 0 || v == 3) ? 3'(v) : 3'h0;
            tc = $urandom;
            wr(12'h154, {5'h1F, 3'h7, 4'hF, 3'(v), 9'h1FF, tc}, 4'hF, 2'b01);
            rd(12'h154, {1'b1, 11'h000, s, 1'b0, 8'h00, tc});
            sync();
            chk("pa_sel", s, ctl_o.pa_sel);
        end
        wr(12'h154, 32'h0, 4'hF, 2'b00);
        rd(12'h154, 32'h0);
        sync();
        chk("vc0_en", 1'b0, ctl_o.vc0_en);
        side[0] = 1'b1;
        sd(4'b0010);
        rd(12'h158, 32'h00030000);
        sync();
        side[0] = 1'b0;
        sd(4'b0001);
        rd(12'h158, 32'h0);
        sync();
        $display("test channel zero resources done");
        final_report();
    end
endmodule
